// file: event_timestamp_sample_store.sv
// Functional notes
// - Phase register bits 2:0 hold the 8 ns slice within the 40 ns period.
// - Phase codes: 000=0 ns, 001=8 ns, 011=24 ns, 100=32 ns.
// - The 16 ns slice uses code 010; codes 101 to 111 are never stored.
// - Nanoseconds bit 30 shows the triggering edge: 1 rising, 0 falling.
// - Nanoseconds bits 29:0 hold the capture time low word in nanoseconds.
// - Seconds register bits 31:0 hold the capture time in seconds.
// - Unit index pointer selects which unit's nanoseconds and seconds are read.
// - Sixth sample: nanoseconds 0x0590, seconds 0x0594, phase 0x0598, 32 bits each.
// - Seventh sample: nanoseconds 0x059C, seconds 0x05A0; fifth phase at 0x058C.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

module event_timestamp_sample_store (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        unit_index_ptr,
  input  wire logic        capture_strobe,
  input  wire logic        capture_unit,
  input  wire logic [1:0]  capture_slot,
  input  wire logic        capture_rising,
  input  wire logic [29:0] capture_nanos,
  input  wire logic [31:0] capture_secs,
  input  wire logic [2:0]  capture_slice
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Index order: [unit][slot], slot 0 = sixth sample, slot 1 = seventh.
  // Phase is kept per slot only, since the phase registers are not indexed.
  typedef struct packed {
    logic [1:0][1:0][29:0] nanos;
    logic [1:0][1:0][31:0] secs;
    logic [1:0][1:0]       polarity;
    logic [2:0][2:0]       phase;
    logic [31:0]           rdata;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ---------------------------------------------------------------
  // Phase encoder
  // ---------------------------------------------------------------
  // Slices above four cannot occur in a 40 ns period; they are stored
  // as code 000 so that a reserved code can never reach software.
  function automatic logic [2:0] encode_phase(input logic [2:0] slice);
    logic [2:0] code;
    code = capture_store_pkg::PHASE_CODE_0NS;
    case (slice)
      3'h1: code = capture_store_pkg::PHASE_CODE_8NS;
      3'h2: code = capture_store_pkg::PHASE_CODE_16NS;
      3'h3: code = capture_store_pkg::PHASE_CODE_24NS;
      3'h4: code = capture_store_pkg::PHASE_CODE_32NS;
      default: code = capture_store_pkg::PHASE_CODE_0NS;
    endcase
    return code;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       hit_sixth;
    logic       hit_seventh;
    logic [2:0] phase_code;
    state_next  = state_reg;
    hit_sixth   = capture_strobe && (capture_slot == capture_store_pkg::SLOT_SIXTH);
    hit_seventh = capture_strobe && (capture_slot == capture_store_pkg::SLOT_SEVENTH);
    // Reference slice to code
    // phase code mapping
    phase_code  = encode_phase(capture_slice);

    // Capture: every field of the hit slot loads in the same cycle
    // one event, all fields
    for (int s = 0; s < 3; s++) begin
      if (capture_strobe && (capture_slot == 2'(s))) begin
        state_next.phase[s] = phase_code;
      end
    end
    for (int s = 0; s < 2; s++) begin
      if ((s == 0 && hit_sixth) || (s == 1 && hit_seventh)) begin
        state_next.polarity[capture_unit][s] = capture_rising;
        state_next.nanos[capture_unit][s]    = capture_nanos;
        state_next.secs[capture_unit][s]     = capture_secs;
      end
    end

    // Read port; writes fall through untouched
    // writes ignored, reserved bits zero
    state_next.rdata = state_reg.rdata;
    if (reg_read) begin
      state_next.rdata = capture_store_pkg::UNMAPPED_VALUE;
      case (reg_addr)
        capture_store_pkg::FIFTH_PHASE_OFFSET: begin
          state_next.rdata = {29'h0000_0000, state_reg.phase[0]};
        end
        capture_store_pkg::SIXTH_NANOS_OFFSET: begin
          state_next.rdata = {1'b0, state_reg.polarity[unit_index_ptr][0],
                              state_reg.nanos[unit_index_ptr][0]};
        end
        capture_store_pkg::SIXTH_SECS_OFFSET: begin
          state_next.rdata = state_reg.secs[unit_index_ptr][0];
        end
        capture_store_pkg::SIXTH_PHASE_OFFSET: begin
          state_next.rdata = {29'h0000_0000, state_reg.phase[1]};
        end
        capture_store_pkg::SEVENTH_NANOS_OFFSET: begin
          state_next.rdata = {1'b0, state_reg.polarity[unit_index_ptr][1],
                              state_reg.nanos[unit_index_ptr][1]};
        end
        capture_store_pkg::SEVENTH_SECS_OFFSET: begin
          state_next.rdata = state_reg.secs[unit_index_ptr][1];
        end
        default: begin
          state_next.rdata = capture_store_pkg::UNMAPPED_VALUE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int u = 0; u < 2; u++) begin
        for (int s = 0; s < 2; s++) begin
          state_reg.nanos[u][s]    <= capture_store_pkg::NANOS_RESET;
          state_reg.secs[u][s]     <= capture_store_pkg::SECS_RESET;
          state_reg.polarity[u][s] <= capture_store_pkg::POLARITY_RESET;
        end
      end
      for (int s = 0; s < 3; s++) begin
        state_reg.phase[s] <= capture_store_pkg::PHASE_RESET;
      end
      state_reg.rdata <= capture_store_pkg::RDATA_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read data holds between reads; the master samples it only after a read
  assign reg_rdata = state_reg.rdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence cap_sixth_unit0;
    capture_strobe && capture_slot == capture_store_pkg::SLOT_SIXTH && !capture_unit;
  endsequence

  sequence read_sixth_nanos_unit0;
    reg_read && reg_addr == capture_store_pkg::SIXTH_NANOS_OFFSET && !unit_index_ptr
      && !capture_strobe;
  endsequence

  sequence cap_seventh_unit1;
    capture_strobe && capture_slot == capture_store_pkg::SLOT_SEVENTH && capture_unit;
  endsequence

  sequence read_seventh_secs_unit1;
    reg_read && reg_addr == capture_store_pkg::SEVENTH_SECS_OFFSET && unit_index_ptr
      && !capture_strobe;
  endsequence

  a_phase_reserved_zero: assert property (
    reg_read && (reg_addr == capture_store_pkg::FIFTH_PHASE_OFFSET
                 || reg_addr == capture_store_pkg::SIXTH_PHASE_OFFSET)
    |=> reg_rdata[31:3] == 29'h0000_0000 && reg_rdata[2:0] <= 3'h4)
    else $error("phase register read shows reserved bits or code");

  a_phase_code_map: assert property (
    capture_strobe && capture_slot == capture_store_pkg::SLOT_FIFTH && capture_slice == 3'h3
    ##1 !capture_strobe
    ##1 reg_read && reg_addr == capture_store_pkg::FIFTH_PHASE_OFFSET && !capture_strobe
    |=> reg_rdata == 32'h0000_0003)
    else $error("24 ns slice not read back as code 011");

  a_phase_sixteen_ns: assert property (
    capture_strobe && capture_slot == capture_store_pkg::SLOT_SIXTH && capture_slice == 3'h2
    |=> state_reg.phase[1] == 3'h2)
    else $error("16 ns slice not stored as code 010");

  a_edge_reported: assert property (
    cap_sixth_unit0 ##1 !capture_strobe ##1 read_sixth_nanos_unit0
    |=> reg_rdata[30] == $past(capture_rising, 3) && reg_rdata[31] == 1'b0)
    else $error("edge bit does not match captured edge");

  a_nanos_low_word: assert property (
    cap_sixth_unit0 ##1 !capture_strobe ##1 read_sixth_nanos_unit0
    |=> reg_rdata[29:0] == $past(capture_nanos, 3))
    else $error("nanoseconds read differs from captured value");

  a_secs_full_word: assert property (
    cap_seventh_unit1 ##1 !capture_strobe ##1 read_seventh_secs_unit1
    |=> reg_rdata == $past(capture_secs, 3))
    else $error("seconds read differs from captured value");

  a_unit_select: assert property (
    cap_seventh_unit1 ##1 !capture_strobe
    ##1 reg_read && reg_addr == capture_store_pkg::SEVENTH_SECS_OFFSET && !unit_index_ptr
        && !capture_strobe
    |=> reg_rdata == $past(state_reg.secs[0][1]))
    else $error("unit pointer did not select unit zero");

  a_unmapped_zero: assert property (
    reg_read && (reg_addr < capture_store_pkg::FIFTH_PHASE_OFFSET
                 || reg_addr > capture_store_pkg::SEVENTH_SECS_OFFSET
                 || reg_addr[1:0] != 2'b00)
    |=> reg_rdata == 32'h0000_0000)
    else $error("address outside the map did not read zero");

  a_write_ignored: assert property (
    reg_write && !capture_strobe
    |=> $stable(state_reg.nanos) && $stable(state_reg.secs) && $stable(state_reg.phase)
        && $stable(state_reg.polarity))
    else $error("write changed a read-only sample field");

  a_capture_together: assert property (
    capture_strobe && capture_slot == capture_store_pkg::SLOT_SEVENTH
    |=> state_reg.nanos[$past(capture_unit)][1] == $past(capture_nanos)
        && state_reg.secs[$past(capture_unit)][1] == $past(capture_secs)
        && state_reg.polarity[$past(capture_unit)][1] == $past(capture_rising)
        && state_reg.phase[2] == encode_phase($past(capture_slice)))
    else $error("sample fields not latched together");

  a_rdata_holds: assert property (
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule

// file: capture_store_pkg.sv
package capture_store_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] FIFTH_PHASE_OFFSET    = 16'h058c;
  localparam logic [15:0] SIXTH_NANOS_OFFSET    = 16'h0590;
  localparam logic [15:0] SIXTH_SECS_OFFSET     = 16'h0594;
  localparam logic [15:0] SIXTH_PHASE_OFFSET    = 16'h0598;
  localparam logic [15:0] SEVENTH_NANOS_OFFSET  = 16'h059c;
  localparam logic [15:0] SEVENTH_SECS_OFFSET   = 16'h05a0;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int NANOS_LSB    = 0;
  localparam int NANOS_WIDTH  = 30;
  localparam int POLARITY_BIT = 30;
  localparam int SECS_WIDTH   = 32;
  localparam int PHASE_LSB    = 0;
  localparam int PHASE_WIDTH  = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [29:0] NANOS_RESET    = 30'h0000_0000;
  localparam logic [31:0] SECS_RESET     = 32'h0000_0000;
  localparam logic        POLARITY_RESET = 1'b0;
  localparam logic [2:0]  PHASE_RESET    = 3'h0;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Phase codes, one per 8 ns slice of the 40 ns reference period
  // ---------------------------------------------------------------
  localparam logic [2:0] PHASE_CODE_0NS  = 3'h0;
  localparam logic [2:0] PHASE_CODE_8NS  = 3'h1;
  localparam logic [2:0] PHASE_CODE_16NS = 3'h2;
  localparam logic [2:0] PHASE_CODE_24NS = 3'h3;
  localparam logic [2:0] PHASE_CODE_32NS = 3'h4;

  // ---------------------------------------------------------------
  // Capture slot selection on the capture port
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SLOT_FIFTH   = 2'b00,
    SLOT_SIXTH   = 2'b01,
    SLOT_SEVENTH = 2'b10,
    SLOT_NONE    = 2'b11
  } slot_type;

endpackage

// file: event_source_model.sv
`timescale 1ns/100ps

module event_source_model (
  input  wire logic        clk_sys,
  output logic             capture_strobe,
  output logic             capture_unit,
  output logic      [1:0]  capture_slot,
  output logic             capture_rising,
  output logic      [29:0] capture_nanos,
  output logic      [31:0] capture_secs,
  output logic      [2:0]  capture_slice
);
  initial begin
    capture_strobe = 1'b0;
    capture_unit   = 1'b0;
    capture_slot   = capture_store_pkg::SLOT_NONE;
    capture_rising = 1'b0;
    capture_nanos  = 30'h0000_0000;
    capture_secs   = 32'h0000_0000;
    capture_slice  = 3'h0;
  end

  // ---------------------------------------------------------------
  // One capture event
  // ---------------------------------------------------------------
  // Edge and time together
  task automatic fire(input logic u, input logic [1:0] s, input logic r,
                      input logic [29:0] n, input logic [31:0] sec, input logic [2:0] ph);
    @(posedge clk_sys);
    capture_strobe <= 1'b1;
    capture_unit   <= u;
    capture_slot   <= s;
    capture_rising <= r;
    capture_nanos  <= n;
    capture_secs   <= sec;
    capture_slice  <= ph;
    @(posedge clk_sys);
    capture_strobe <= 1'b0;
    // Stale fields other than the slot are inverted so a late latch cannot pass unseen
    capture_unit   <= ~u;
    capture_rising <= ~r;
    capture_nanos  <= ~n;
    capture_secs   <= ~sec;
    capture_slice  <= ~ph;
  endtask
endmodule

// file: event_timestamp_sample_store_test.sv
`timescale 1ns/100ps

module event_timestamp_sample_store_test;
  logic        clk_sys;
  logic        resetn;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic        unit_index_ptr;
  logic        capture_strobe;
  logic        capture_unit;
  logic [1:0]  capture_slot;
  logic        capture_rising;
  logic [29:0] capture_nanos;
  logic [31:0] capture_secs;
  logic [2:0]  capture_slice;
  int          fails;
  int          cmp_count;

  event_timestamp_sample_store u_event_timestamp_sample_store (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .unit_index_ptr(unit_index_ptr), .capture_strobe(capture_strobe),
    .capture_unit(capture_unit), .capture_slot(capture_slot),
    .capture_rising(capture_rising), .capture_nanos(capture_nanos),
    .capture_secs(capture_secs), .capture_slice(capture_slice));

  event_source_model u_event_source_model (
    .clk_sys(clk_sys), .capture_strobe(capture_strobe), .capture_unit(capture_unit),
    .capture_slot(capture_slot), .capture_rising(capture_rising),
    .capture_nanos(capture_nanos), .capture_secs(capture_secs),
    .capture_slice(capture_slice));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Bus and report helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    logic [15:0] map [8];
    map = '{16'h058c, 16'h0590, 16'h0594, 16'h0598, 16'h059c, 16'h05a0, 16'h05a4, 16'h0591};
    for (int i = 0; i < 8; i++) begin
      rd(map[i], 32'h0000_0000, "reset value");
    end
  endtask

  task automatic test_sixth();
    u_event_source_model.fire(1'b1, 2'b01, 1'b0, 30'h1555_aaaa, 32'h8765_4321, 3'h1);
    u_event_source_model.fire(1'b0, 2'b01, 1'b1, 30'h2aaa_5555, 32'h1234_5678, 3'h1);
    unit_index_ptr <= 1'b0;
    rd(16'h0590, {1'b0, 1'b1, 30'h2aaa_5555}, "sixth nanos unit 0");
    rd(16'h0594, 32'h1234_5678, "sixth secs unit 0");
    unit_index_ptr <= 1'b1;
    rd(16'h0590, {1'b0, 1'b0, 30'h1555_aaaa}, "sixth nanos unit 1");
    rd(16'h0594, 32'h8765_4321, "sixth secs unit 1");
    rd(16'h0598, 32'h0000_0001, "sixth phase");
    // Slot none and bus writes must both leave the store alone
    u_event_source_model.fire(1'b1, 2'b11, 1'b1, 30'h3fff_ffff, 32'hffff_ffff, 3'h4);
    wr(16'h0590, 32'hffff_ffff);
    wr(16'h0594, 32'h0000_0000);
    rd(16'h0590, {1'b0, 1'b0, 30'h1555_aaaa}, "sixth nanos after write");
    rd(16'h0594, 32'h8765_4321, "sixth secs after write");
  endtask

  task automatic test_seventh();
    u_event_source_model.fire(1'b1, 2'b10, 1'b1, 30'h0000_0001, 32'hffff_ffff, 3'h4);
    unit_index_ptr <= 1'b1;
    rd(16'h05a0, 32'hffff_ffff, "seventh secs unit 1");
    rd(16'h059c, {1'b0, 1'b1, 30'h0000_0001}, "seventh nanos unit 1");
    unit_index_ptr <= 1'b0;
    rd(16'h059c, 32'h0000_0000, "seventh nanos unit 0");
    rd(16'h0598, 32'h0000_0001, "sixth phase untouched");
  endtask

  task automatic test_phase();
    logic [2:0] code [5];
    code = '{capture_store_pkg::PHASE_CODE_0NS, capture_store_pkg::PHASE_CODE_8NS,
             capture_store_pkg::PHASE_CODE_16NS, capture_store_pkg::PHASE_CODE_24NS,
             capture_store_pkg::PHASE_CODE_32NS};
    for (int i = 0; i < 5; i++) begin
      u_event_source_model.fire(1'b0, 2'b00, 1'b0, 30'h3fff_ffff, 32'h0000_0000, 3'(i));
      rd(16'h058c, {29'h0000_0000, code[i]}, "fifth phase");
    end
    rd(16'h0590, {1'b0, 1'b1, 30'h2aaa_5555}, "sixth nanos after fifth");
  endtask

  initial begin
    resetn         = 1'b0;
    reg_addr       = 16'h0000;
    reg_wdata      = 32'h0000_0000;
    reg_write      = 1'b0;
    reg_read       = 1'b0;
    unit_index_ptr = 1'b0;
    fails          = 0;
    cmp_count      = 0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    test_reset();
    test_sixth();
    test_seventh();
    test_phase();
    finish_test();
  end

  // Guard against a stuck run
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    finish_test();
  end
endmodule
